// ===== design/pisc_flag.sv
`timescale 1ns/1ns
`default_nettype none

// One sticky pending flag: the source sets it, any clear path drops it.
module pisc_flag (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclken,
   input wire logic set_pulse,
   input wire logic clr_pulse,
   output logic flag_q
);

   pisc_pkg::pisc_flag_st_t st_r; // Registered state.
   pisc_pkg::pisc_flag_st_t st_nxt; // Next state.

   // A set in the same cycle as a clear wins so no event is lost.
   always_comb begin
      st_nxt = st_r;
      if (set_pulse) begin
         st_nxt.flag = 1'b1;
      end else if (clr_pulse) begin
         st_nxt.flag = 1'b0;
      end
   end

   // Synchronous reset; the clock enable freezes the flag.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r.flag <= 1'b0;
      end else if (aclken) begin
         st_r <= st_nxt;
      end
   end

   assign flag_q = st_r.flag;

endmodule : pisc_flag

`default_nettype wire

// ===== design/pisc_top.sv
// Operation
// - Second PWM flag cleared by zero or off
// - Fourth timer flag cleared by zero or config
// - Port flag cleared by zero or select zero
// - Watchdog flag cleared by zero or control write
// - Third timer flag cleared by zero or config
// - First PWM flag cleared by zero or off
// - LCD flag cleared by zero or scan write
// - LED flag cleared by zero or scan write
// - Flags show pending state, zero after reset
// - Scan bit zero starts scanning, resets zero
// - Pending at AEH, scan control at AFH
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pisc_regs.svh"

module pisc_top (
   input wire logic aclk,
   input wire logic aclken,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] irq_src_set,
   input wire logic pwm_b_off_evt,
   input wire logic timer_d_config_wr,
   input wire logic port_irq_input_select_zero_wr,
   input wire logic watchdog_control_wr,
   input wire logic timer_c_config_wr,
   input wire logic pwm_a_off_evt,
   output logic [7:0] peripheral_irq_pending,
   output logic scan_enable,
   output logic irq
);

   pisc_pkg::pisc_top_st_t st_r; // Registered state.
   pisc_pkg::pisc_top_st_t st_nxt; // Next state.
   logic [7:0] flag_clr; // Clear request per flag this cycle.
   logic [7:0] flag_set; // Set request per flag this cycle.
   logic wr_do; // A buffered write is carried out this cycle.
   pisc_pkg::pisc_reg_t wr_sel; // Register hit by that write.
   pisc_pkg::pisc_reg_t rd_sel; // Register hit by an accepted read.

   // Address decode, shared by the read and write paths.
   function automatic pisc_pkg::pisc_reg_t pisc_dec(input logic [11:0] a);
      if (a == {`PISC_PEND_IDX, 2'b00}) begin
         return pisc_pkg::PISC_REG_PEND;
      end else if (a == {`PISC_SCAN_IDX, 2'b00}) begin
         return pisc_pkg::PISC_REG_SCAN;
      end else if (a == `PISC_IEN_ADDR) begin
         return pisc_pkg::PISC_REG_IEN;
      end else if (a == `PISC_ICLR_ADDR) begin
         return pisc_pkg::PISC_REG_ICLR;
      end else begin
         return pisc_pkg::PISC_REG_NONE;
      end
   endfunction : pisc_dec

   assign wr_sel = pisc_dec(st_r.awaddr);
   assign rd_sel = pisc_dec(s_axi_araddr);
   // The write fires once address and data are both held and the
   // previous response has been taken.
   assign wr_do = st_r.aw_got && st_r.w_got && !st_r.bvalid;

   // Collect every clear path. Only lane 0 carries register bits, so a
   // write without it stores nothing and clears nothing.
   always_comb begin
      flag_clr = 8'h00;
      if (wr_do && st_r.wstb0) begin
         unique case (wr_sel)
            pisc_pkg::PISC_REG_PEND: begin
               // Zeros clear, ones leave the flag alone.
               flag_clr = ~st_r.wdata;
            end
            pisc_pkg::PISC_REG_SCAN: begin
               flag_clr[`PISC_BIT_LCD] = 1'b1;
               flag_clr[`PISC_BIT_LED] = 1'b1;
            end
            pisc_pkg::PISC_REG_ICLR: begin
               flag_clr = st_r.wdata;
            end
            pisc_pkg::PISC_REG_IEN, pisc_pkg::PISC_REG_NONE: begin
               flag_clr = 8'h00;
            end
         endcase
      end
      flag_clr[`PISC_BIT_PWM_B] = flag_clr[`PISC_BIT_PWM_B] |
         pwm_b_off_evt;
      flag_clr[`PISC_BIT_TIMER_D] = flag_clr[`PISC_BIT_TIMER_D] |
         timer_d_config_wr;
      flag_clr[`PISC_BIT_PORT] = flag_clr[`PISC_BIT_PORT] |
         port_irq_input_select_zero_wr;
      flag_clr[`PISC_BIT_WDOG] = flag_clr[`PISC_BIT_WDOG] |
         watchdog_control_wr;
      flag_clr[`PISC_BIT_TIMER_C] = flag_clr[`PISC_BIT_TIMER_C] |
         timer_c_config_wr;
      flag_clr[`PISC_BIT_PWM_A] = flag_clr[`PISC_BIT_PWM_A] |
         pwm_a_off_evt;
   end

   // Sources are on this clock, so their pulses need no synchroniser.
   assign flag_set = irq_src_set;

   // One sticky cell per source.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         pisc_flag u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .aclken(aclken),
            .set_pulse(flag_set[gi]),
            .clr_pulse(flag_clr[gi]),
            .flag_q(peripheral_irq_pending[gi])
         );
      end
   endgenerate

   // Bus slave, control registers and interrupt output.
   always_comb begin
      st_nxt = st_r;
      // Capture address and data independently, in either order.
      if (s_axi_awvalid && st_r.aw_rdy) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.w_rdy) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata[7:0];
         st_nxt.wstb0 = s_axi_wstrb[0];
      end
      if (wr_do) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `PISC_RESP_OKAY;
         unique case (wr_sel)
            pisc_pkg::PISC_REG_SCAN: begin
               if (st_r.wstb0) begin
                  st_nxt.scan = st_r.wdata[`PISC_SCAN_BIT];
               end
            end
            pisc_pkg::PISC_REG_IEN: begin
               if (st_r.wstb0) begin
                  st_nxt.ien = st_r.wdata;
               end
            end
            pisc_pkg::PISC_REG_PEND, pisc_pkg::PISC_REG_ICLR: begin
               // Flag effects are handled by the clear collector.
               st_nxt.bresp = `PISC_RESP_OKAY;
            end
            pisc_pkg::PISC_REG_NONE: begin
               st_nxt.bresp = `PISC_RESP_SLVERR;
            end
         endcase
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      // Hold off new writes until the response has been taken.
      st_nxt.aw_rdy = !st_nxt.aw_got && !st_nxt.bvalid;
      st_nxt.w_rdy = !st_nxt.w_got && !st_nxt.bvalid;
      // Reads: one outstanding, answered on the next cycle.
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.ar_rdy) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `PISC_RESP_OKAY;
         unique case (rd_sel)
            pisc_pkg::PISC_REG_PEND: begin
               st_nxt.rdata = {24'h000000,
                  peripheral_irq_pending};
            end
            pisc_pkg::PISC_REG_SCAN: begin
               // Reserved bits read as zero.
               st_nxt.rdata = {31'h00000000, st_r.scan};
            end
            pisc_pkg::PISC_REG_IEN: begin
               st_nxt.rdata = {24'h000000, st_r.ien};
            end
            pisc_pkg::PISC_REG_ICLR: begin
               // Write-only register reads as zero.
               st_nxt.rdata = 32'h00000000;
            end
            pisc_pkg::PISC_REG_NONE: begin
               st_nxt.rdata = 32'h00000000;
               st_nxt.rresp = `PISC_RESP_SLVERR;
            end
         endcase
      end
      st_nxt.ar_rdy = !st_nxt.rvalid;
      // The level output lags the flags by one cycle, which keeps it a
      // clean flop at the cost of one cycle of latency.
      st_nxt.irq = |(peripheral_irq_pending & st_r.ien);
   end

   // Synchronous reset; the clock enable freezes all state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r.aw_rdy <= 1'b0;
         st_r.w_rdy <= 1'b0;
         st_r.aw_got <= 1'b0;
         st_r.w_got <= 1'b0;
         st_r.awaddr <= 12'h000;
         st_r.wdata <= 8'h00;
         st_r.wstb0 <= 1'b0;
         st_r.bvalid <= 1'b0;
         st_r.bresp <= `PISC_RESP_OKAY;
         st_r.ar_rdy <= 1'b0;
         st_r.rvalid <= 1'b0;
         st_r.rdata <= 32'h00000000;
         st_r.rresp <= `PISC_RESP_OKAY;
         st_r.scan <= `PISC_SCAN_RST;
         st_r.ien <= `PISC_IEN_RST;
         st_r.irq <= 1'b0;
      end else if (aclken) begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = st_r.aw_rdy;
   assign s_axi_wready = st_r.w_rdy;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.ar_rdy;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign scan_enable = st_r.scan;
   assign irq = st_r.irq;

   // Checks run on the one clock; reset disables them unless overridden.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Switching off the second PWM channel drops its flag.
   property p_pwm_b_off;
      aclken && pwm_b_off_evt && !irq_src_set[7] |=>
         !peripheral_irq_pending[7];
   endproperty
   a_pwm_b_off: assert property (p_pwm_b_off)
      else $error("pwm b flag not cleared by channel off");

   // A fourth-timer config write drops its flag.
   property p_timer_d_cfg;
      aclken && timer_d_config_wr && !irq_src_set[6] |=>
         !peripheral_irq_pending[6];
   endproperty
   a_timer_d_cfg: assert property (p_timer_d_cfg)
      else $error("timer d flag not cleared by config write");

   // Selecting no port input drops the port flag.
   property p_port_sel;
      aclken && port_irq_input_select_zero_wr && !irq_src_set[5] |=>
         !peripheral_irq_pending[5];
   endproperty
   a_port_sel: assert property (p_port_sel)
      else $error("port flag not cleared by select zero");

   // A watchdog control write drops its flag.
   property p_wdog_ctl;
      aclken && watchdog_control_wr && !irq_src_set[4] |=>
         !peripheral_irq_pending[4];
   endproperty
   a_wdog_ctl: assert property (p_wdog_ctl)
      else $error("watchdog flag not cleared by control write");

   // A scan-control write clears both display flags.
   property p_scan_clr;
      aclken && wr_do && st_r.wstb0 && wr_sel == pisc_pkg::PISC_REG_SCAN
         && irq_src_set[1:0] == 2'b00 |=>
         peripheral_irq_pending[1:0] == 2'b00 && scan_enable ==
         $past(st_r.wdata[0]);
   endproperty
   a_scan_clr: assert property (p_scan_clr)
      else $error("scan write did not clear display flags");

   // Flags are zero right after reset.
   property p_reset_zero;
      disable iff (1'b0) !aresetn |=> peripheral_irq_pending == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("flags not zero after reset");

   // A read of the pending index returns the flags of the accept cycle.
   property p_rd_pend;
      aclken && s_axi_arvalid && s_axi_arready &&
         rd_sel == pisc_pkg::PISC_REG_PEND |=>
         s_axi_rvalid && s_axi_rdata[7:0] == $past(peripheral_irq_pending);
   endproperty
   a_rd_pend: assert property (p_rd_pend)
      else $error("pending read returned wrong data");

   // Every set reaches its flag, whatever clears arrive with it.
   property p_set_wins;
      aclken && irq_src_set != 8'h00 |=>
         (peripheral_irq_pending & $past(irq_src_set)) ==
         $past(irq_src_set);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("set event lost");

   // Writing all ones to the pending register changes nothing.
   property p_ones_keep;
      aclken && wr_do && st_r.wstb0 && wr_sel == pisc_pkg::PISC_REG_PEND
         && st_r.wdata == 8'hff && flag_clr == 8'h00 |=>
         peripheral_irq_pending == ($past(peripheral_irq_pending) |
         $past(irq_src_set));
   endproperty
   a_ones_keep: assert property (p_ones_keep)
      else $error("writing one altered a flag");

   // Main scenarios.
   c_flag_set: cover property (aclken && irq_src_set != 8'h00);
   c_sw_clear: cover property (aclken && wr_do &&
      wr_sel == pisc_pkg::PISC_REG_PEND);
   c_scan_on: cover property (scan_enable);
   c_irq: cover property (irq);

endmodule : pisc_top

`default_nettype wire

// ===== pkg/pisc_pkg.sv
package pisc_pkg;

   // Which register an address selects.
   typedef enum logic [2:0] {
      PISC_REG_PEND,
      PISC_REG_SCAN,
      PISC_REG_IEN,
      PISC_REG_ICLR,
      PISC_REG_NONE
   } pisc_reg_t;

   // State of one pending flag cell.
   typedef struct packed {
      logic flag;
   } pisc_flag_st_t;

   // State of the top module: bus slave and control registers.
   typedef struct packed {
      logic aw_rdy;
      logic w_rdy;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [7:0] wdata;
      logic wstb0;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic scan;
      logic [7:0] ien;
      logic irq;
   } pisc_top_st_t;

endpackage : pisc_pkg

// ===== pkg/pisc_regs.svh
`ifndef PISC_REGS_SVH
`define PISC_REGS_SVH

// Register indices as printed; the byte address is four times the index.
`define PISC_PEND_IDX 10'h0ae
`define PISC_SCAN_IDX 10'h0af

// Interrupt enable and write-one-to-clear registers, byte addresses.
`define PISC_IEN_ADDR 12'h300
`define PISC_ICLR_ADDR 12'h304

// Reset values.
`define PISC_PEND_RST 8'h00
`define PISC_SCAN_RST 1'b0
`define PISC_IEN_RST 8'h00

// Flag positions inside the pending register.
`define PISC_BIT_PWM_B 7
`define PISC_BIT_TIMER_D 6
`define PISC_BIT_PORT 5
`define PISC_BIT_WDOG 4
`define PISC_BIT_TIMER_C 3
`define PISC_BIT_PWM_A 2
`define PISC_BIT_LCD 1
`define PISC_BIT_LED 0

// Scan enable position inside the scan-control register.
`define PISC_SCAN_BIT 0

// AXI response codes.
`define PISC_RESP_OKAY 2'h0
`define PISC_RESP_SLVERR 2'h2

`endif

// ===== test/peripheral_irq_status_and_scan_start_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pisc_regs.svh"

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, e); end end

module peripheral_irq_status_and_scan_start_tb;
   // Byte addresses are four times the printed register index.
   localparam logic [11:0] A_PEND = {`PISC_PEND_IDX, 2'b00};
   localparam logic [11:0] A_SCAN = {`PISC_SCAN_IDX, 2'b00};
   logic aclk = 1'b0, aresetn = 1'b0, aclken = 1'b1;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, s_axi_rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, scan_enable, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] req = '0, src_set, pend, rd;
   logic [5:0] sc = '0;
   int n_fail = 0, cmp_count = 0, cyc = 0;

   // The clock is 250 MHz.
   always #2 aclk = ~aclk;

   pisc_src_model SRC (.aclk(aclk), .req(req), .irq_src_set(src_set));

   pisc_top DUT (.aclk(aclk), .aclken(aclken), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(rready), .irq_src_set(src_set),
      .pwm_b_off_evt(sc[5]), .timer_d_config_wr(sc[4]),
      .port_irq_input_select_zero_wr(sc[3]),
      .watchdog_control_wr(sc[2]), .timer_c_config_wr(sc[1]),
      .pwm_a_off_evt(sc[0]), .peripheral_irq_pending(pend),
      .scan_enable(scan_enable), .irq(irq));

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // A hang is cut short well beyond the few hundred cycles needed.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   // One write; address and data are offered together and each released
   // at the edge that takes it. Outputs read here are pre-edge values.
   // Only the bench timeout ends a wait for the response.
   task automatic axw(input logic [11:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) awvalid <= 1'b0;
         if (s_axi_wready) wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      bready <= 1'b0;
      r = s_axi_bresp;
   endtask : axw

   // One read; the answer is taken at the edge where rvalid is seen.
   task automatic axr(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rready <= 1'b0;
      rd = s_axi_rdata[7:0];
      r = s_axi_rresp;
   endtask : axr

   // Raises source events for one cycle and lets the flags settle.
   task automatic fire(input logic [7:0] m);
      @(posedge aclk);
      req <= m;
      @(posedge aclk);
      req <= 8'h00;
      repeat (2) @(posedge aclk);
   endtask : fire

   // Every register starts cleared.
   task automatic t_reset();
      `CHK(pend, `PISC_PEND_RST)
      axr(A_SCAN);
      `CHK(rd, 8'h00)
      axr(`PISC_IEN_ADDR);
      `CHK(rd, `PISC_IEN_RST)
   endtask : t_reset

   // Clearing one flag by zero while writing one to the rest.
   task automatic t_swclr();
      logic [7:0] x;
      for (int k = 0; k < 8; k++) begin
         x = ~(8'h01 << k);
         fire(8'hff);
         axw(A_PEND, x);
         `CHK(pend, x)
         axr(A_PEND);
         `CHK(rd, x)
      end
      // Ones written to the pending register leave every flag alone.
      axw(A_PEND, 8'hff);
      `CHK(pend, 8'h7f)
   endtask : t_swclr

   // Each side path drops only its own flag.
   task automatic t_side();
      logic [7:0] x;
      for (int i = 0; i < 6; i++) begin
         x = ~(8'h04 << i);
         fire(8'hff);
         sc <= 6'h01 << i;
         @(posedge aclk);
         sc <= 6'h00;
         @(posedge aclk);
         `CHK(pend, x)
      end
   endtask : t_side

   // A set and a side clear landing on one edge leave the flag set.
   task automatic t_setwins();
      axw(A_PEND, 8'h00);
      req <= 8'h80;
      @(posedge aclk);
      req <= 8'h00;
      sc <= 6'h20;
      @(posedge aclk);
      sc <= 6'h00;
      @(posedge aclk);
      `CHK(pend, 8'h80)
   endtask : t_setwins

   // A scan-control write with lane 0 starts or stops scanning and drops bits 1:0.
   task automatic t_scan();
      fire(8'hff);
      axw(A_SCAN, 8'h01);
      `CHK({scan_enable, pend}, 9'h1fc)
      axr(A_SCAN);
      `CHK(rd, 8'h01)
      fire(8'h03);
      axw(A_SCAN, 8'h00);
      `CHK({scan_enable, pend}, 9'h0fc)
   endtask : t_scan

   // The line follows an enabled flag, then masking; a clear then drops the flag.
   task automatic t_irq();
      axw(A_PEND, 8'h00);
      axw(`PISC_IEN_ADDR, 8'h01);
      fire(8'h01);
      // The line is registered from the flags, so it rises one edge later.
      @(posedge aclk);
      `CHK(irq, 1'b1)
      axw(`PISC_IEN_ADDR, 8'h00);
      @(posedge aclk);
      `CHK(irq, 1'b0)
      axw(`PISC_ICLR_ADDR, 8'h01);
      `CHK(pend, 8'h00)
   endtask : t_irq

   // Unmapped places answer with an error and change nothing.
   task automatic t_unmap();
      axr(12'h7f0);
      `CHK({r, rd}, {`PISC_RESP_SLVERR, 8'h00})
      fire(8'hff);
      axw(12'h2b4, 8'h00);
      `CHK(r, `PISC_RESP_SLVERR)
      `CHK(pend, 8'hff)
   endtask : t_unmap

   // A low clock enable freezes the flags against sets and side clears.
   task automatic t_cken();
      axw(A_PEND, 8'h00);
      fire(8'h10);
      aclken <= 1'b0;
      sc <= 6'h04;
      fire(8'h20);
      `CHK(pend, 8'h10)
      sc <= 6'h00;
      aclken <= 1'b1;
   endtask : t_cken

   // A reset in mid-run drops the flags and the scan bit again.
   task automatic t_rst2();
      fire(8'hff);
      axw(A_SCAN, 8'h01);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK({scan_enable, pend}, 9'h000)
      axr(A_PEND);
      `CHK(rd, `PISC_PEND_RST)
   endtask : t_rst2

   // Reset for four cycles, then the scenarios in turn.
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_swclr();
      t_side();
      t_setwins();
      t_scan();
      t_irq();
      t_unmap();
      t_cken();
      t_rst2();
      report_and_stop();
   end
endmodule : peripheral_irq_status_and_scan_start_tb

`default_nettype wire

// ===== test/pisc_src_model.sv
`timescale 1ns/1ns
`default_nettype none

// Stand-in for the on-chip interrupt sources. Each request from the bench
// turns into a set pulse one edge later, as a real source would emit it.
module pisc_src_model (
   input wire logic aclk,
   input wire logic [7:0] req,
   output logic [7:0] irq_src_set
);
   // Registering keeps the pulse clear of the edge that samples it.
   always_ff @(posedge aclk) begin
      irq_src_set <= req;
   end
endmodule : pisc_src_model

`default_nettype wire
